// [tui_float.sv]
// temperature input reporting: shared package and float scaling datapath
// assumes one clock domain; the datapath below is purely combinational
package tui_pkg;

  localparam int TUI_CHANS = 4;
  localparam int TUI_VAL_W = 24;

  // register map, byte addresses; region in paddr[7:4], channel in paddr[3:2]
  localparam logic [7:0] TUI_ADDR_STATUS = 8'h00;
  localparam logic [7:0] TUI_ADDR_EVT = 8'h04;
  localparam logic [7:0] TUI_ADDR_MASK = 8'h08;
  localparam logic [7:0] TUI_ADDR_CTRL = 8'h0C;
  localparam logic [7:0] TUI_ADDR_CFG_ALL = 8'h10;
  localparam logic [7:0] TUI_ADDR_CFG0 = 8'h20;
  localparam logic [7:0] TUI_ADDR_SCALE0 = 8'h30;
  localparam logic [7:0] TUI_ADDR_INT0 = 8'h40;
  localparam logic [7:0] TUI_ADDR_REAL0 = 8'h50;

  // channel config fields
  localparam int TUI_CFG_W = 6;
  localparam int TUI_CFG_EN = 0;
  localparam int TUI_CFG_TYPE_LSB = 1;
  localparam int TUI_CFG_PROBE_LSB = 3;
  localparam logic [TUI_CFG_W-1:0] TUI_CFG_RESET = 6'h00;

  // control fields
  localparam int TUI_CTL_W = 3;
  localparam int TUI_CTL_FAHR = 0;
  localparam int TUI_CTL_REJ60 = 1;
  localparam int TUI_CTL_BURN = 2;
  localparam logic [TUI_CTL_W-1:0] TUI_CTL_RESET = 3'h4;

  typedef enum logic [1:0] {
    TUI_TYPE_TC = 2'h0,
    TUI_TYPE_RTD = 2'h1,
    TUI_TYPE_THERM = 2'h2,
    TUI_TYPE_VOLT = 2'h3
  } tui_type_e;

  localparam logic signed [TUI_VAL_W-1:0] TUI_INT_MAX = 24'sh007FFF;
  localparam logic signed [TUI_VAL_W-1:0] TUI_INT_MIN = 24'shFF8000;
  localparam logic signed [TUI_VAL_W-1:0] TUI_MV62_MIN = 24'shFFC000;
  localparam logic signed [TUI_VAL_W-1:0] TUI_MV125_MIN = 24'shFFE000;
  localparam logic signed [TUI_VAL_W-1:0] TUI_V1_MIN = 24'sh000000;

  // float constants
  localparam logic [31:0] TUI_FLOAT_TENTH = 32'h3DCCCCCD;
  localparam logic [31:0] TUI_FLOAT_ONE = 32'h3F800000;
  localparam int TUI_MANT_BITS = 23;
  localparam logic signed [10:0] TUI_EXP_MAX = 11'sh0FF;

  typedef struct packed {
    logic signed [TUI_VAL_W-1:0] lo;
    logic signed [TUI_VAL_W-1:0] hi;
  } tui_bounds_s;

  function automatic tui_bounds_s tui_mk(input int lo, input int hi);
    tui_bounds_s b;
    b.lo = 24'(lo);
    b.hi = 24'(hi);
    return b;
  endfunction

  // selected range in tenths of a degree, or in counts for voltage
  function automatic tui_bounds_s tui_bounds(input tui_type_e t, input logic [2:0] p,
                                             input logic fahr);
    tui_bounds_s b;
    b = tui_mk(-32768, 32767);
    case (t)
      TUI_TYPE_TC:
        case (p)
          3'h0: b = fahr ? tui_mk(-3460, 21920) : tui_mk(-2100, 12000);
          3'h1: b = fahr ? tui_mk(-4450, 25020) : tui_mk(-2650, 13720);
          3'h2: b = fahr ? tui_mk(-4450, 18320) : tui_mk(-2650, 10000);
          3'h3, 3'h4: b = fahr ? tui_mk(-580, 32140) : tui_mk(-500, 17680);
          3'h5: b = fahr ? tui_mk(1040, 33080) : tui_mk(400, 18200);
          default: b = fahr ? tui_mk(-4450, 7520) : tui_mk(-2650, 4000);
        endcase
      TUI_TYPE_RTD:
        b = (p == 3'h6) ? (fahr ? tui_mk(-1120, 5000) : tui_mk(-800, 2600))
                        : (fahr ? tui_mk(-3280, 15620) : tui_mk(-2000, 8500));
      TUI_TYPE_THERM:
        b = fahr ? tui_mk(-400, 3020) : tui_mk(-400, 1500);
      default:
        case (p)
          3'h0: b.lo = TUI_INT_MIN;
          3'h1: b.lo = TUI_MV62_MIN;
          3'h2: b.lo = TUI_MV125_MIN;
          default: b.lo = TUI_V1_MIN;
        endcase
    endcase
    if (t == TUI_TYPE_VOLT)
    begin
      b.hi = TUI_INT_MAX;
    end
    return b;
  endfunction

endpackage

`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// signed 24-bit integer times an ieee single factor, truncated to single
module tui_float_mul
  import tui_pkg::*;
(
  input wire logic signed [tui_pkg::TUI_VAL_W-1:0] val,
  input wire logic [31:0] scale,
  output logic [31:0] product
);

  function automatic logic [4:0] lead_zeros(input logic [23:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 24; i++)
    begin
      if (v[i])
      begin
        n = 5'(23 - i);
      end
    end
    return n;
  endfunction

  logic sgn;
  logic [23:0] mag;
  logic [4:0] lz;
  logic [23:0] norm;
  logic [47:0] prod;
  logic [22:0] frac;
  logic signed [10:0] expo;

  always_comb
  begin
    sgn = val[TUI_VAL_W-1];
    mag = sgn ? 24'(-val) : 24'(val);
    lz = lead_zeros(mag);
    norm = mag << lz;
    prod = {24'h0, norm} * {24'h0, 1'b1, scale[22:0]};
    frac = prod[47] ? prod[46:24] : prod[45:23];
    expo = 11'(scale[30:23]) + 11'(TUI_MANT_BITS) - 11'(lz) + 11'(prod[47]);
    if (mag == 24'h0 || scale[30:23] == 8'h00 || expo <= 11'sh000)
    begin
      product = 32'h0;
    end
    else if (expo >= TUI_EXP_MAX)
    begin
      product = {sgn ^ scale[31], 8'hFF, 23'h0};
    end
    else
    begin
      product = {sgn ^ scale[31], expo[7:0], frac};
    end
  end

endmodule

// [tui_report.sv]
// temperature input reporting block: apb registers, value words, status byte
// assumes samples come from converter logic on CLK, one per cycle at most
//
// Overview of operation
// R1: temperature integer word in rounded tenths
// R2: temperature real word as 24-bit float; the code gives a 32-bit ieee single
// R3: integer saturates at 32767, float full range
// R4: millivolt integer word bounded per range
// R5: voltage real word uses user scale factor
// R6: status byte presented as one aligned byte
// R7: status bits: range then burnout, per channel
// R8: range flag when input outside selected range
// R9: burnout flag while loop open, if enabled
// R10: only enabled channels converted and reported
// R11: per-channel sensor type and probe selection
// R12: settings written to one or all channels
// R13: fixed units per count for integer word
// R14: host matches rejection to mains frequency
// R15: values refreshed per conversion, held otherwise
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps

module tui_report
  import tui_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SAMPLE_VALID,
  input wire logic [1:0] SAMPLE_CHAN,
  input wire logic signed [tui_pkg::TUI_VAL_W-1:0] SAMPLE_VALUE,
  input wire logic SAMPLE_OPEN,
  output logic [tui_pkg::TUI_CHANS-1:0] CHAN_ENABLE,
  output logic [7:0] STATUS_BYTE,
  output logic FAHRENHEIT,
  output logic REJECT_60HZ,
  output logic IRQ
);

  import tui_pkg::*;

  typedef struct packed {
    logic [TUI_CHANS-1:0][TUI_CFG_W-1:0] cfg;
    logic [TUI_CHANS-1:0][31:0] scale;
    logic [TUI_CHANS-1:0][15:0] ival;
    logic [TUI_CHANS-1:0][31:0] rval;
    logic [7:0] flags;
    logic [7:0] evt;
    logic [7:0] mask;
    logic [TUI_CTL_W-1:0] ctl;
    logic [31:0] rdata;
    logic slverr;
  } tui_state_s;

  tui_state_s s_q;
  tui_state_s s_d;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic tui_type_e cfg_type(input logic [TUI_CFG_W-1:0] c);
    return tui_type_e'(c[TUI_CFG_TYPE_LSB +: 2]);
  endfunction

  function automatic logic [2:0] cfg_probe(input logic [TUI_CFG_W-1:0] c);
    return c[TUI_CFG_PROBE_LSB +: 3];
  endfunction

  function automatic logic signed [TUI_VAL_W-1:0] clamp(
    input logic signed [TUI_VAL_W-1:0] v,
    input logic signed [TUI_VAL_W-1:0] lo,
    input logic signed [TUI_VAL_W-1:0] hi);
    if (v < lo)
    begin
      return lo;
    end
    else if (v > hi)
    begin
      return hi;
    end
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // sample path

  logic [TUI_CFG_W-1:0] smp_cfg;
  tui_type_e smp_type;
  tui_bounds_s smp_bnd;
  logic signed [TUI_VAL_W-1:0] smp_lo;
  logic smp_take;
  logic smp_oor;
  logic smp_open;
  logic [31:0] smp_scale;
  logic [31:0] smp_real;

  always_comb
  begin
    smp_cfg = s_q.cfg[SAMPLE_CHAN];
    smp_type = cfg_type(smp_cfg);
    smp_bnd = tui_bounds(smp_type, cfg_probe(smp_cfg), s_q.ctl[TUI_CTL_FAHR]); // R11
    smp_take = SAMPLE_VALID && smp_cfg[TUI_CFG_EN]; // R10
    smp_oor = (SAMPLE_VALUE < smp_bnd.lo) || (SAMPLE_VALUE > smp_bnd.hi); // R8
    smp_open = SAMPLE_OPEN && s_q.ctl[TUI_CTL_BURN]; // R9
    smp_lo = (smp_type == TUI_TYPE_VOLT) ? smp_bnd.lo : TUI_INT_MIN; // R4
    // temperatures scale tenths to degrees, voltage uses the user factor
    smp_scale = (smp_type == TUI_TYPE_VOLT) ? s_q.scale[SAMPLE_CHAN] // R5
                                            : TUI_FLOAT_TENTH; // R2
  end

  tui_float_mul u_fmul (
    .val(SAMPLE_VALUE),
    .scale(smp_scale),
    .product(smp_real)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setup_ph;
  logic wr_acc;
  logic [3:0] rgn;
  logic [1:0] ach;
  logic dec_ok;
  logic [31:0] rd_mux;

  always_comb
  begin
    setup_ph = PSEL && !PENABLE;
    wr_acc = PSEL && PENABLE && PWRITE;
    rgn = PADDR[7:4];
    ach = PADDR[3:2];
    dec_ok = 1'b0;
    rd_mux = 32'h0;
    if (PADDR[1:0] == 2'b00)
    begin
      if (rgn == TUI_ADDR_STATUS[7:4])
      begin
        dec_ok = 1'b1;
        case (PADDR)
          TUI_ADDR_STATUS: rd_mux = {24'h0, s_q.flags}; // R6
          TUI_ADDR_EVT: rd_mux = {24'h0, s_q.evt};
          TUI_ADDR_MASK: rd_mux = {24'h0, s_q.mask};
          default: rd_mux = {29'h0, s_q.ctl};
        endcase
      end
      else if (PADDR == TUI_ADDR_CFG_ALL)
      begin
        dec_ok = 1'b1;
      end
      else if (rgn == TUI_ADDR_CFG0[7:4])
      begin
        dec_ok = 1'b1;
        rd_mux = {26'h0, s_q.cfg[ach]};
      end
      else if (rgn == TUI_ADDR_SCALE0[7:4])
      begin
        dec_ok = 1'b1;
        rd_mux = s_q.scale[ach];
      end
      else if (rgn == TUI_ADDR_INT0[7:4])
      begin
        dec_ok = 1'b1;
        rd_mux = {{16{s_q.ival[ach][15]}}, s_q.ival[ach]}; // R13
      end
      else if (rgn == TUI_ADDR_REAL0[7:4])
      begin
        dec_ok = 1'b1;
        rd_mux = s_q.rval[ach];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic [7:0] evt_set;
  logic [7:0] evt_clr;
  logic [1:0] new_flags;

  always_comb
  begin
    s_d = s_q;
    evt_set = 8'h00;
    evt_clr = 8'h00;
    new_flags = {smp_open, smp_oor};
    if (smp_take)
    begin
      s_d.ival[SAMPLE_CHAN] = 16'(clamp(SAMPLE_VALUE, smp_lo, TUI_INT_MAX)); // R1 R3 R4
      s_d.rval[SAMPLE_CHAN] = smp_real; // R2 R15
      s_d.flags[{SAMPLE_CHAN, 1'b0} +: 2] = new_flags; // R7 R8 R9
      evt_set[SAMPLE_CHAN] = 1'b1;
      evt_set[4 + SAMPLE_CHAN] = |(new_flags & ~s_q.flags[{SAMPLE_CHAN, 1'b0} +: 2]);
    end
    if (setup_ph)
    begin
      s_d.rdata = PWRITE ? 32'h0 : rd_mux;
      s_d.slverr = !dec_ok;
    end
    if (wr_acc && dec_ok)
    begin
      if (PADDR == TUI_ADDR_EVT)
      begin
        evt_clr = PWDATA[7:0];
      end
      else if (PADDR == TUI_ADDR_MASK)
      begin
        s_d.mask = PWDATA[7:0];
      end
      else if (PADDR == TUI_ADDR_CTRL)
      begin
        s_d.ctl = PWDATA[TUI_CTL_W-1:0];
      end
      else if (PADDR == TUI_ADDR_CFG_ALL)
      begin
        for (int c = 0; c < TUI_CHANS; c++)
        begin
          s_d.cfg[c] = PWDATA[TUI_CFG_W-1:0]; // R12
        end
      end
      else if (rgn == TUI_ADDR_CFG0[7:4])
      begin
        s_d.cfg[ach] = PWDATA[TUI_CFG_W-1:0]; // R11 R12
      end
      else if (rgn == TUI_ADDR_SCALE0[7:4])
      begin
        s_d.scale[ach] = PWDATA;
      end
    end
    // a fresh event beats a simultaneous write-one-to-clear
    s_d.evt = (s_q.evt & ~evt_clr) | evt_set;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s_q.cfg <= {TUI_CHANS{TUI_CFG_RESET}};
      s_q.scale <= {TUI_CHANS{TUI_FLOAT_ONE}};
      s_q.ival <= '0;
      s_q.rval <= '0;
      s_q.flags <= 8'h00;
      s_q.evt <= 8'h00;
      s_q.mask <= 8'h00;
      s_q.ctl <= TUI_CTL_RESET;
      s_q.rdata <= 32'h0;
      s_q.slverr <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb
  begin
    PRDATA = s_q.rdata;
    PREADY = 1'b1;
    PSLVERR = PSEL && PENABLE && s_q.slverr;
    for (int c = 0; c < TUI_CHANS; c++)
    begin
      CHAN_ENABLE[c] = s_q.cfg[c][TUI_CFG_EN]; // R10
    end
    STATUS_BYTE = s_q.flags; // R6 R7
    FAHRENHEIT = s_q.ctl[TUI_CTL_FAHR];
    REJECT_60HZ = s_q.ctl[TUI_CTL_REJ60]; // R14
    IRQ = |(s_q.evt & s_q.mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic temp_take;
  assign temp_take = smp_take && (smp_type != TUI_TYPE_VOLT);

  property p_int_sat;
    @(posedge CLK) disable iff (RESET)
    temp_take && (SAMPLE_VALUE > TUI_INT_MAX) |=> s_q.ival[$past(SAMPLE_CHAN)] == 16'h7FFF;
  endproperty
  a_int_sat: assert property (p_int_sat) else $error("integer word not saturated"); // R3

  property p_int_tenths;
    @(posedge CLK) disable iff (RESET)
    temp_take && !smp_oor
      && (SAMPLE_VALUE <= TUI_INT_MAX)
      |=> s_q.ival[$past(SAMPLE_CHAN)] == $past(SAMPLE_VALUE[15:0]);
  endproperty
  a_int_tenths: assert property (p_int_tenths) else $error("tenths word mismatch"); // R1

  property p_real_one;
    @(posedge CLK) disable iff (RESET)
    temp_take && (SAMPLE_VALUE == 24'sh00000A)
      |=> s_q.rval[$past(SAMPLE_CHAN)] == TUI_FLOAT_ONE;
  endproperty
  a_real_one: assert property (p_real_one) else $error("ten tenths not 1.0"); // R2

  property p_mv_floor;
    @(posedge CLK) disable iff (RESET)
    smp_take && (smp_type == TUI_TYPE_VOLT) && (cfg_probe(smp_cfg) == 3'h2)
      && (SAMPLE_VALUE < TUI_MV125_MIN)
      |=> (s_q.ival[$past(SAMPLE_CHAN)] == 16'hE000)
        && STATUS_BYTE[{$past(SAMPLE_CHAN), 1'b0}];
  endproperty
  a_mv_floor: assert property (p_mv_floor) else $error("mV floor wrong"); // R4

  property p_range_flag;
    @(posedge CLK) disable iff (RESET)
    smp_take && smp_oor |=> STATUS_BYTE[{$past(SAMPLE_CHAN), 1'b0}];
  endproperty
  a_range_flag: assert property (p_range_flag) else $error("range flag missing"); // R8

  property p_burnout;
    @(posedge CLK) disable iff (RESET)
    smp_take && SAMPLE_OPEN
      |=> STATUS_BYTE[{$past(SAMPLE_CHAN), 1'b1}] == $past(s_q.ctl[TUI_CTL_BURN]);
  endproperty
  a_burnout: assert property (p_burnout) else $error("burnout flag wrong"); // R9

  property p_disabled;
    @(posedge CLK) disable iff (RESET)
    SAMPLE_VALID && !smp_cfg[TUI_CFG_EN]
      |=> (s_q.ival[$past(SAMPLE_CHAN)] == $past(s_q.ival[SAMPLE_CHAN]))
        && (!s_q.evt[$past(SAMPLE_CHAN)] || $past(s_q.evt[SAMPLE_CHAN]));
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel updated"); // R10

  property p_evt_mark;
    @(posedge CLK) disable iff (RESET)
    smp_take |=> s_q.evt[$past(SAMPLE_CHAN)];
  endproperty
  a_evt_mark: assert property (p_evt_mark) else $error("update event not marked"); // R15

  property p_hold;
    @(posedge CLK) disable iff (RESET)
    !SAMPLE_VALID |=> $stable(s_q.rval) && $stable(s_q.flags);
  endproperty
  a_hold: assert property (p_hold) else $error("values changed without sample"); // R15

endmodule

// [tui_host_model.sv]
// host-side apb master model for the reporting block
// assumes one rising-edge clock shared with the block
`timescale 1ns/10ps

module tui_host_model
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////
  // one transfer: setup, then access until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// [test_tui_report.sv]
// self-checking bench for the temperature reporting block
// assumes tui_pkg register map and the host apb model
`timescale 1ns/10ps

module test_tui_report;
  import tui_pkg::*;
  typedef struct {
    logic [5:0] cfg;
    logic [1:0] ch;
    logic signed [23:0] v;
    logic op;
    logic [31:0] ei;
    logic [31:0] er;
    logic [7:0] es;
  } tui_row_s;
  tui_row_s rows [0:6] = '{
    '{6'h01, 2'h0, 24'sh002EEA, 1'b0, 32'h00002EEA, 32'h44962000, 8'h01},
    '{6'h29, 2'h1, 24'sh008138, 1'b0, 32'h00007FFF, 32'h454EC000, 8'h05},
    '{6'h0F, 2'h2, 24'shFFB1E0, 1'b0, 32'hFFFFC000, 32'hC69C4000, 8'h15},
    '{6'h03, 2'h3, 24'shFFF826, 1'b1, 32'hFFFFF826, 32'hC3490000, 8'hD5},
    '{6'h05, 2'h0, 24'sh0005DC, 1'b0, 32'h000005DC, 32'h43160000, 8'hD4},
    '{6'h05, 2'h0, 24'sh00000A, 1'b0, 32'h0000000A, 32'h3F800000, 8'hD4},
    '{6'h17, 2'h3, 24'shFFD8F0, 1'b1, 32'hFFFFE000, 32'hC61C4000, 8'hD4}};
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [7:0] PADDR, STATUS_BYTE;
  logic [31:0] PWDATA, PRDATA, q;
  logic SAMPLE_VALID, SAMPLE_OPEN, FAHRENHEIT, REJECT_60HZ, e;
  logic [1:0] SAMPLE_CHAN;
  logic signed [23:0] SAMPLE_VALUE;
  logic [3:0] CHAN_ENABLE;
  int err_count = 0;
  int total_checks = 0;

  tui_report i_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_CHAN(SAMPLE_CHAN),
    .SAMPLE_VALUE(SAMPLE_VALUE), .SAMPLE_OPEN(SAMPLE_OPEN), .CHAN_ENABLE(CHAN_ENABLE),
    .STATUS_BYTE(STATUS_BYTE), .FAHRENHEIT(FAHRENHEIT), .REJECT_60HZ(REJECT_60HZ),
    .IRQ(IRQ));
  tui_host_model i_host (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

  ////////////////////////////////////////
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ofs(input logic [1:0] c);
    return {4'h0, c, 2'h0};
  endfunction
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic er;
    i_host.xfer(1'b0, a, 32'h0, d, er);
    chk(32'(er), 32'h0);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    i_host.xfer(1'b1, a, d, r, er);
  endtask
  task automatic go(input logic [1:0] c, input logic signed [23:0] v, input logic op);
    @(posedge CLK);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_CHAN <= c;
    SAMPLE_VALUE <= v;
    SAMPLE_OPEN <= op;
  endtask
  task automatic stop();
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
  endtask
  task automatic settle();
    @(posedge CLK);
    #1;
  endtask
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial
  begin
    #1000000;
    err_count++;
    close_out();
  end

  initial
  begin
    RESET = 1'b1;
    SAMPLE_VALID = 1'b0;
    SAMPLE_CHAN = 2'h0;
    SAMPLE_VALUE = 24'sh0;
    SAMPLE_OPEN = 1'b0;
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    settle();
    chk(32'({CHAN_ENABLE, STATUS_BYTE, IRQ, FAHRENHEIT, REJECT_60HZ}), 32'h0);
    rdchk(TUI_ADDR_CTRL, 32'h4);
    rdchk(TUI_ADDR_SCALE0, 32'h3F800000);
    wr(TUI_ADDR_STATUS, 32'hFF);
    rdchk(TUI_ADDR_STATUS, 32'h0);
    i_host.xfer(1'b0, 8'hF0, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    foreach (rows[i])
    begin
      wr(TUI_ADDR_CFG0 + ofs(rows[i].ch), 32'(rows[i].cfg));
      go(rows[i].ch, rows[i].v, rows[i].op);
      stop();
      rdchk(TUI_ADDR_INT0 + ofs(rows[i].ch), rows[i].ei);
      rdchk(TUI_ADDR_REAL0 + ofs(rows[i].ch), rows[i].er);
      chk(32'(STATUS_BYTE), 32'(rows[i].es));
      rdchk(TUI_ADDR_STATUS, 32'(rows[i].es));
    end
    // event, mask and level interrupt
    chk(32'(IRQ), 32'h0);
    rdchk(TUI_ADDR_EVT, 32'hFF);
    wr(TUI_ADDR_MASK, 32'h10);
    settle();
    chk(32'(IRQ), 32'h1);
    wr(TUI_ADDR_EVT, 32'h10);
    settle();
    chk(32'(IRQ), 32'h0);
    rdchk(TUI_ADDR_EVT, 32'hEF);
    // all channels disabled: sample ignored, words held
    wr(TUI_ADDR_CFG_ALL, 32'h0);
    settle();
    chk(32'(CHAN_ENABLE), 32'h0);
    go(2'h2, 24'sh0, 1'b0);
    stop();
    rdchk(TUI_ADDR_INT0 + ofs(2'h2), 32'hFFFFC000);
    rdchk(TUI_ADDR_EVT, 32'hEF);
    // fahrenheit, 60 Hz, user scale, back-to-back samples
    wr(TUI_ADDR_CTRL, 32'h7);
    wr(TUI_ADDR_CFG0 + ofs(2'h1), 32'h29);
    wr(TUI_ADDR_CFG0 + ofs(2'h2), 32'h0F);
    wr(TUI_ADDR_SCALE0 + ofs(2'h2), 32'h40000000);
    settle();
    chk(32'({CHAN_ENABLE, FAHRENHEIT, REJECT_60HZ}), 32'h1B);
    go(2'h1, 24'sh008138, 1'b0);
    go(2'h2, 24'shFFB1E0, 1'b0);
    stop();
    settle();
    chk(32'(STATUS_BYTE), 32'hD0);
    rdchk(TUI_ADDR_INT0 + ofs(2'h1), 32'h00007FFF);
    rdchk(TUI_ADDR_REAL0 + ofs(2'h2), 32'hC71C4000);
    // burnout detection off
    wr(TUI_ADDR_CTRL, 32'h3);
    wr(TUI_ADDR_CFG0 + ofs(2'h3), 32'h03);
    go(2'h3, 24'sh0, 1'b1);
    stop();
    settle();
    chk(32'(STATUS_BYTE), 32'h10);
    // reset in mid-run clears the words and restores defaults
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    settle();
    chk(32'({CHAN_ENABLE, STATUS_BYTE, IRQ, FAHRENHEIT, REJECT_60HZ}), 32'h0);
    rdchk(TUI_ADDR_INT0 + ofs(2'h1), 32'h0);
    rdchk(TUI_ADDR_CTRL, 32'h4);
    close_out();
  end
endmodule
